//--- rtl/dma_chan_ctrl.sv
// control logic for one dma channel pair (a and b): apb registers,
// activation source selection, arbitration, address and count stepping.
// assumes the bus side takes xfer_req and answers with a one-cycle
// xfer_ack on sys_clk; timer and serial events are sys_clk pulses.
//
// Operation
// - control registers clear on reset and standby
// - enabled channel transfers on each selected event
// - disabled channel ignores all requests
// - enable sets only after read-while-zero then write
// - io and idle modes clear enable at end
// - end irq on enable clear when enabled
// - size bit picks byte or word unit
// - io/repeat step address up or down 1/2
// - idle mode leaves memory address unchanged
// - repeat and irq-enable bits choose the mode
// - codes 0-3 pick timer channels 0-3
// - codes 4/5 pick serial empty/full
// - b: external edge/low; a: full mode
// - shared source served in fixed priority
// - selected source withheld from cpu while enabled
// - full mode: a source, b destination, both step
// - address top byte ignores writes, reads ones
// - address registers not reset
// - full mode ignores io address registers
// - full mode: a count down to zero, b unused
// - a select bits 2:1 both one pair the channels
// - repeat: high byte counts, reloads from low
// - short mode io address upper bits all ones
// - receive-full makes memory address the destination
`timescale 1ns/1ps
`default_nettype none
module dma_chan_ctrl
(
   input  wire logic                              sys_clk,
   input  wire logic                              rst,
   input  wire logic                              standby,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [dma_chan_pkg::PADDR_W-1:0]  paddr,
   input  wire logic [31:0]                       pwdata,
   output logic      [31:0]                       prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic [3:0]                        timer_match,
   input  wire logic                              serial_tx_empty,
   input  wire logic                              serial_rx_full,
   input  wire logic                              external_request_pin_n,
   output logic      [3:0]                        cpu_timer_irq,
   output logic                                   cpu_tx_empty_irq,
   output logic                                   cpu_rx_full_irq,
   output logic      [1:0]                        transfer_end_irq,
   output logic                                   xfer_req,
   output logic      [31:0]                       xfer_src_addr,
   output logic      [31:0]                       xfer_dst_addr,
   output logic                                   xfer_word,
   output logic                                   xfer_chan,
   input  wire logic                              xfer_ack
);
   import dma_chan_pkg::*;

   function automatic logic src_fire(input logic [2:0] code,
                                     input logic [3:0] tmr,
                                     input logic       txe,
                                     input logic       rxf,
                                     input logic       edge_ev,
                                     input logic       low_ev);
      logic f;
      f = 1'b0;
      if (code <= SRC_TMR3)
         f = tmr[code[1:0]];
      else if (code == SRC_TXE)
         f = txe;
      else if (code == SRC_RXF)
         f = rxf;
      else if (code == SRC_EXT_EDGE)
         f = edge_ev;
      else
         f = low_ev;
      return f;
   endfunction

   function automatic logic [23:0] step_addr(input logic [23:0] a,
                                             input logic        word,
                                             input logic        down);
      logic [23:0] s;
      s = word ? STEP_WORD : STEP_BYTE;
      return down ? a - s : a + s;
   endfunction

   logic [7:0]   ctrl_r [2];
   logic [23:0]  mar_r [2];
   logic [7:0]   io_port_address_r [2];
   logic [15:0]  cnt_r [2];
   logic [1:0]   arm_r;
   logic [1:0]   pend_r;
   logic [1:0]   en_d_r;
   logic         ext_s1_r;
   logic         ext_s2_r;
   logic         ext_s3_r;
   logic         cur_r;
   xfer_state_e  state_r;
   logic         full;
   logic [2:0]   code0;
   logic [1:0]   fire;
   logic [5:0]   withheld;
   logic         commit;
   logic         capture;
   logic         wr;
   logic         ach;
   logic [3:0]   aofs;
   logic         mapped;
   logic [31:0]  rd_val;
   logic         done;
   logic [1:0]   end_hit;
   logic         serve;
   logic         serve_ch;

   assign full     = ctrl_r[0][SEL_HI] & ctrl_r[0][SEL_MID];
   assign commit   = psel & penable & pready;
   assign capture  = psel & penable & ~pready;
   assign wr       = commit & pwrite & mapped;
   assign ach      = paddr[CHAN_BIT];
   assign aofs     = paddr[3:0];
   assign mapped   = (paddr[PADDR_W-1:MAP_TOP] == '0);
   assign done     = (state_r == ST_BUSY) & xfer_ack;
   assign serve    = (state_r == ST_IDLE) & (|pend_r);
   assign serve_ch = ~pend_r[0];

   // full mode is triggered through the b channel's source code
   assign code0 = full ? ctrl_r[1][SEL_HI:0] : ctrl_r[0][SEL_HI:0];

   always_comb
   begin
      fire[0] = ctrl_r[0][EN_BIT]
                & src_fire(code0, timer_match, serial_tx_empty,
                           serial_rx_full, ext_s3_r & ~ext_s2_r,
                           ~ext_s2_r);
      fire[1] = ctrl_r[1][EN_BIT] & ~full
                & src_fire(ctrl_r[1][SEL_HI:0], timer_match,
                           serial_tx_empty, serial_rx_full,
                           ext_s3_r & ~ext_s2_r, ~ext_s2_r);
   end

   always_comb
   begin
      withheld = '0;
      if (ctrl_r[0][EN_BIT] && code0 <= SRC_RXF)
         withheld[code0] = 1'b1;
      if (ctrl_r[1][EN_BIT] && !full && ctrl_r[1][SEL_HI:0] <= SRC_RXF)
         withheld[ctrl_r[1][SEL_HI:0]] = 1'b1;
   end

   always_comb
   begin
      rd_val = '0;
      if (aofs == OFS_CTRL)
         rd_val = {24'h000000, ctrl_r[ach]};
      else if (aofs == OFS_ADDR)
         rd_val = {ADDR_TOP, mar_r[ach]};
      else if (aofs == OFS_IOADDR)
         rd_val = {24'h000000, io_port_address_r[ach]};
      else if (aofs == OFS_COUNT)
         rd_val = {16'h0000, cnt_r[ach]};
   end

   // end of transfer for the channel being served
   always_comb
   begin
      end_hit = '0;
      if (done)
      begin
         if (full)
            end_hit[0] = (cnt_r[0] == COUNT_ONE);
         else if (!(ctrl_r[cur_r][RPT_BIT] && !ctrl_r[cur_r][IE_BIT]))
            end_hit[cur_r] = (cnt_r[cur_r] == COUNT_ONE);
      end
   end

   // external request pin synchroniser plus one stage for edges
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ext_s1_r <= 1'b1;
         ext_s2_r <= 1'b1;
         ext_s3_r <= 1'b1;
      end
      else
      begin
         ext_s1_r <= external_request_pin_n;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // apb answer: one wait cycle, data and error taken with pready
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= capture;
         pslverr <= capture & ~mapped;
         if (capture && !pwrite)
            prdata <= mapped ? rd_val : '0;
      end
   end

   // control registers: software write, then hardware end clear
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r[0] <= CTRL_RESET;
         ctrl_r[1] <= CTRL_RESET;
         arm_r     <= '0;
      end
      else if (standby)
      begin
         ctrl_r[0] <= CTRL_RESET;
         ctrl_r[1] <= CTRL_RESET;
         arm_r     <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (capture && !pwrite && mapped && ach == i[0]
                && aofs == OFS_CTRL && !ctrl_r[i][EN_BIT])
               arm_r[i] <= 1'b1;
            if (wr && ach == i[0] && aofs == OFS_CTRL)
            begin
               ctrl_r[i]         <= pwdata[7:0];
               ctrl_r[i][EN_BIT] <= pwdata[EN_BIT]
                                    & (ctrl_r[i][EN_BIT] | arm_r[i]);
               arm_r[i]          <= 1'b0;
            end
            if (end_hit[i])
               ctrl_r[i][EN_BIT] <= 1'b0;
         end
      end
   end

   // address, io address and count: never reset, hardware wins
   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (wr && ach == i[0] && aofs == OFS_ADDR)
            mar_r[i] <= pwdata[23:0];
         if (wr && ach == i[0] && aofs == OFS_IOADDR)
            io_port_address_r[i] <= pwdata[7:0];
         if (wr && ach == i[0] && aofs == OFS_COUNT)
            cnt_r[i] <= pwdata[15:0];
      end
      if (done && full)
      begin
         mar_r[0] <= step_addr(mar_r[0], ctrl_r[0][SIZE_BIT],
                               ctrl_r[0][DIR_BIT]);
         mar_r[1] <= step_addr(mar_r[1], ctrl_r[0][SIZE_BIT],
                               ctrl_r[1][DIR_BIT]);
         cnt_r[0] <= cnt_r[0] - COUNT_ONE;
      end
      else if (done)
      begin
         if (!(ctrl_r[cur_r][RPT_BIT] && ctrl_r[cur_r][IE_BIT]))
            mar_r[cur_r] <= step_addr(mar_r[cur_r],
                                      ctrl_r[cur_r][SIZE_BIT],
                                      ctrl_r[cur_r][DIR_BIT]);
         if (ctrl_r[cur_r][RPT_BIT] && !ctrl_r[cur_r][IE_BIT])
         begin
            if (cnt_r[cur_r][15:8] == BYTE_ONE)
               cnt_r[cur_r][15:8] <= cnt_r[cur_r][7:0];
            else
               cnt_r[cur_r][15:8] <= cnt_r[cur_r][15:8] - BYTE_ONE;
         end
         else
            cnt_r[cur_r] <= cnt_r[cur_r] - COUNT_ONE;
      end
   end

   // pending requests: a new event wins over the serve clear
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         pend_r <= '0;
      else if (standby)
         pend_r <= '0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (fire[i])
               pend_r[i] <= 1'b1;
            else if (!ctrl_r[i][EN_BIT] || (i == 1 && full))
               pend_r[i] <= 1'b0;
            else if (serve && serve_ch == i[0])
               pend_r[i] <= 1'b0;
         end
      end
   end

   // transfer request towards the bus
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r       <= ST_IDLE;
         cur_r         <= 1'b0;
         xfer_req      <= 1'b0;
         xfer_src_addr <= '0;
         xfer_dst_addr <= '0;
         xfer_word     <= 1'b0;
         xfer_chan     <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (serve)
               begin
                  state_r   <= ST_BUSY;
                  cur_r     <= serve_ch;
                  xfer_chan <= serve_ch;
                  xfer_req  <= 1'b1;
                  xfer_word <= ctrl_r[serve_ch][SIZE_BIT];
                  if (full)
                  begin
                     xfer_src_addr <= {ADDR_TOP, mar_r[0]};
                     xfer_dst_addr <= {ADDR_TOP, mar_r[1]};
                  end
                  else if (ctrl_r[serve_ch][SEL_HI:0] == SRC_RXF)
                  begin
                     xfer_src_addr <= {IO_HIGH, io_port_address_r[serve_ch]};
                     xfer_dst_addr <= {ADDR_TOP, mar_r[serve_ch]};
                  end
                  else
                  begin
                     xfer_src_addr <= {ADDR_TOP, mar_r[serve_ch]};
                     xfer_dst_addr <= {IO_HIGH, io_port_address_r[serve_ch]};
                  end
               end
            end
            ST_BUSY:
            begin
               if (xfer_ack)
               begin
                  state_r  <= ST_IDLE;
                  xfer_req <= 1'b0;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // interrupts to the cpu: withheld sources and transfer end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cpu_timer_irq    <= '0;
         cpu_tx_empty_irq <= 1'b0;
         cpu_rx_full_irq  <= 1'b0;
         transfer_end_irq <= '0;
         en_d_r           <= '0;
      end
      else
      begin
         cpu_timer_irq    <= timer_match & ~withheld[3:0];
         cpu_tx_empty_irq <= serial_tx_empty & ~withheld[SRC_TXE];
         cpu_rx_full_irq  <= serial_rx_full & ~withheld[SRC_RXF];
         for (int i = 0; i < 2; i++)
         begin
            en_d_r[i] <= ctrl_r[i][EN_BIT];
            transfer_end_irq[i] <= ctrl_r[i][IE_BIT] & ~ctrl_r[i][EN_BIT]
                                   & (en_d_r[i] | transfer_end_irq[i]);
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/dma_chan_pkg.sv
// constants for the two-channel dma control block: register map,
// control field positions, activation codes and fixed address parts.
// assumes a 32-bit apb with an 8-bit byte address.
package dma_chan_pkg;
   localparam int        PADDR_W       = 8;
   // register byte offsets inside one channel window
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_ADDR     = 4'h4;
   localparam logic [3:0] OFS_IOADDR   = 4'h8;
   localparam logic [3:0] OFS_COUNT    = 4'hc;
   localparam int        CHAN_BIT      = 4;
   localparam int        MAP_TOP       = 5;
   // control field positions
   localparam int        EN_BIT        = 7;
   localparam int        SIZE_BIT      = 6;
   localparam int        DIR_BIT       = 5;
   localparam int        RPT_BIT       = 4;
   localparam int        IE_BIT        = 3;
   localparam int        SEL_HI        = 2;
   localparam int        SEL_MID       = 1;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   // activation source codes
   localparam logic [2:0] SRC_TMR3     = 3'h3;
   localparam logic [2:0] SRC_TXE      = 3'h4;
   localparam logic [2:0] SRC_RXF      = 3'h5;
   localparam logic [2:0] SRC_EXT_EDGE = 3'h6;
   localparam logic [2:0] SRC_EXT_LOW  = 3'h7;
   // fixed address parts and steps
   localparam logic [7:0]  ADDR_TOP    = 8'hff;
   localparam logic [23:0] IO_HIGH     = 24'hffffff;
   localparam logic [23:0] STEP_BYTE   = 24'h000001;
   localparam logic [23:0] STEP_WORD   = 24'h000002;
   localparam logic [15:0] COUNT_ZERO  = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [7:0]  BYTE_ONE    = 8'h01;
   localparam logic [15:0] COUNT_ONE   = 16'h0001;
   typedef enum logic {ST_IDLE, ST_BUSY} xfer_state_e;
endpackage

//--- verification/dma_chan_ctrl_chk.sv
// port-level checker for the dma channel pair control block.
// assumes it is bound to dma_chan_ctrl, everything on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dma_chan_ctrl_chk
   import dma_chan_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        standby,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic [3:0]  timer_match,
   input wire logic        serial_tx_empty,
   input wire logic        serial_rx_full,
   input wire logic [3:0]  cpu_timer_irq,
   input wire logic        cpu_tx_empty_irq,
   input wire logic        cpu_rx_full_irq,
   input wire logic        xfer_req,
   input wire logic        xfer_ack,
   input wire logic [31:0] xfer_src_addr,
   input wire logic [31:0] xfer_dst_addr,
   input wire logic        xfer_word,
   input wire logic        xfer_chan
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_timer_held;
      (cpu_timer_irq & ~$past(timer_match)) == 4'h0;
   endproperty
   a_timer_held: assert property (p_timer_held)
      else $error("timer irq to cpu without a timer event");
   property p_txe_held;
      cpu_tx_empty_irq |-> $past(serial_tx_empty);
   endproperty
   a_txe_held: assert property (p_txe_held)
      else $error("tx empty irq to cpu without an event");
   property p_rxf_held;
      cpu_rx_full_irq |-> $past(serial_rx_full);
   endproperty
   a_rxf_held: assert property (p_rxf_held)
      else $error("rx full irq to cpu without an event");
   property p_top_byte;
      xfer_req |-> xfer_src_addr[31:24] == ADDR_TOP
                   && xfer_dst_addr[31:24] == ADDR_TOP;
   endproperty
   a_top_byte: assert property (p_top_byte)
      else $error("transfer address top byte not all ones");
   property p_req_hold;
      xfer_req && !xfer_ack |=> xfer_req && $stable(xfer_src_addr)
         && $stable(xfer_dst_addr) && $stable({xfer_word, xfer_chan});
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("transfer request changed before acknowledge");
   property p_req_drop;
      xfer_req && xfer_ack |=> !xfer_req;
   endproperty
   a_req_drop: assert property (p_req_drop)
      else $error("transfer request held after acknowledge");
   property p_standby_quiet;
      $past(standby, 2) |-> !$rose(xfer_req);
   endproperty
   a_standby_quiet: assert property (p_standby_quiet)
      else $error("transfer started after standby");
   property p_apb_answer;
      $rose(penable) && psel |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("register access not answered in second cycle");
endmodule
bind dma_chan_ctrl dma_chan_ctrl_chk chk_u (.sys_clk, .rst, .standby,
   .psel, .penable, .pready, .timer_match, .serial_tx_empty,
   .serial_rx_full, .cpu_timer_irq, .cpu_tx_empty_irq, .cpu_rx_full_irq,
   .xfer_req, .xfer_ack, .xfer_src_addr, .xfer_dst_addr, .xfer_word,
   .xfer_chan);
`default_nettype wire

//--- verification/bus_side_model.sv
// system bus model: answers each transfer request with a one-cycle
// acknowledge after ack_delay waiting cycles. assumes sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module bus_side_model
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       xfer_req,
   input  wire logic [3:0] ack_delay,
   output logic            xfer_ack
);
   logic [3:0] wait_r;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst || xfer_ack)
      begin
         wait_r   <= 4'h0;
         xfer_ack <= 1'b0;
      end
      else if (xfer_req)
      begin
         xfer_ack <= (wait_r == ack_delay);
         wait_r   <= wait_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- verification/dma_channel_control_modes_tb_top.sv
// self-checking bench for the dma channel pair control block.
// assumes 200 MHz sys_clk; registers reached over apb.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_modes_tb_top;
   import dma_chan_pkg::*;
   logic        sys_clk, rst, standby, psel, penable, pwrite;
   logic        pready, pslverr, rerr, serial_tx_empty, serial_rx_full;
   logic        external_request_pin_n, cpu_tx_empty_irq, cpu_rx_full_irq;
   logic        xfer_req, xfer_word, xfer_chan, xfer_ack;
   logic [3:0]  timer_match, cpu_timer_irq, ack_delay;
   logic [1:0]  transfer_end_irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, xfer_src_addr, xfer_dst_addr, rdat;
   logic [6:0]  seen;
   int          n_mismatch, check_count;
   dma_chan_ctrl dut_u
   (
      .sys_clk, .rst, .standby, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .timer_match, .serial_tx_empty,
      .serial_rx_full, .external_request_pin_n, .cpu_timer_irq,
      .cpu_tx_empty_irq, .cpu_rx_full_irq, .transfer_end_irq, .xfer_req,
      .xfer_src_addr, .xfer_dst_addr, .xfer_word, .xfer_chan, .xfer_ack
   );
   bus_side_model model_u (.sys_clk, .rst, .xfer_req, .ack_delay, .xfer_ack);
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // sticky record of requests and cpu irqs, sampled mid-cycle
   always @(negedge sys_clk)
      seen <= seen | {xfer_req, cpu_rx_full_irq, cpu_tx_empty_irq,
                      cpu_timer_irq};
   task automatic chk(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
      if (n == 20)
      begin
         chk("pready", 1, 0);
         wrap_up();
      end
   endtask
   task automatic wr(input logic ch, input logic [3:0] o,
                     input logic [31:0] d);
      apb(1'b1, {3'h0, ch, o}, d);
   endtask
   task automatic rc(input logic ch, input logic [3:0] o,
                     input logic [31:0] exp, input string what);
      apb(1'b0, {3'h0, ch, o}, 32'h0);
      chk(what, exp, rdat);
   endtask
   // enable needs a read while the channel is off first
   task automatic en(input logic ch, input logic [7:0] v);
      apb(1'b0, {3'h0, ch, OFS_CTRL}, 32'h0);
      wr(ch, OFS_CTRL, {24'h0, v});
   endtask
   task automatic setup(input logic ch, input logic [31:0] a, io, cnt);
      wr(ch, OFS_ADDR, a);
      wr(ch, OFS_IOADDR, io);
      wr(ch, OFS_COUNT, cnt);
   endtask
   task automatic fire(input int k);
      if (k < 4)
         timer_match <= 4'h1 << k;
      serial_tx_empty <= (k == 4);
      serial_rx_full <= (k == 5);
      external_request_pin_n <= (k < 6);
      @(posedge sys_clk);
      timer_match <= 4'h0;
      serial_tx_empty <= 1'b0;
      serial_rx_full <= 1'b0;
      external_request_pin_n <= 1'b1;
   endtask
   task automatic get(input logic ch, input logic [31:0] s, d,
                      input logic w);
      int n;
      n = 0;
      while (xfer_req !== 1'b1 && n < 30)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("xfer_req", 1, xfer_req);
      if (xfer_req !== 1'b1)
         wrap_up();
      chk("xfer_chan", ch, xfer_chan);
      chk("xfer_src_addr", s, xfer_src_addr);
      chk("xfer_dst_addr", d, xfer_dst_addr);
      chk("xfer_word", w, xfer_word);
      while (xfer_req === 1'b1 && n < 60)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 60)
      begin
         chk("xfer_req end", 0, 1);
         wrap_up();
      end
   endtask
   task automatic t_regs();
      wr(1'b0, OFS_CTRL, 32'h80);
      rc(1'b0, OFS_CTRL, 32'h0, "enable without read");
      rc(1'b1, OFS_CTRL, 32'h0, "ctrl b reset");
      wr(1'b0, OFS_ADDR, 32'h12345678);
      rc(1'b0, OFS_ADDR, 32'hff345678, "address top");
      en(1'b0, 8'h81);
      rc(1'b0, OFS_CTRL, 32'h81, "enable after read");
      standby <= 1'b1;
      @(posedge sys_clk);
      standby <= 1'b0;
      rc(1'b0, OFS_CTRL, 32'h0, "ctrl after standby");
      rc(1'b0, OFS_ADDR, 32'hff345678, "address kept");
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped pslverr", 1, rerr);
      chk("unmapped prdata", 0, rdat);
   endtask
   task automatic t_prio();
      for (int c = 0; c < 4; c++)
      begin
         setup(1'b0, 32'h100, 32'h40, 32'h1);
         setup(1'b1, 32'h200, 32'h41, 32'h1);
         en(1'b0, 8'h80 | c[7:0]);
         en(1'b1, 8'h80 | c[7:0]);
         seen = 7'h0;
         fire(c);
         get(1'b0, 32'hff000100, 32'hffffff40, 1'b0);
         get(1'b1, 32'hff000200, 32'hffffff41, 1'b0);
         chk("cpu irq withheld", 32'h40, seen);
         rc(1'b0, OFS_CTRL, c, "ctrl after end");
         rc(1'b0, OFS_ADDR, 32'hff000101, "address up");
         seen = 7'h0;
         fire(c);
         repeat (8) @(posedge sys_clk);
         chk("disabled channel", 32'h1 << c, seen);
      end
   endtask
   task automatic t_repeat();
      ack_delay <= 4'h5;
      setup(1'b1, 32'h200, 32'h50, 32'h0202);
      en(1'b1, 8'hf5);
      seen = 7'h0;
      for (int i = 0; i < 3; i++)
      begin
         fire(5);
         get(1'b1, 32'hffffff50, 32'hff000200 - 32'(2 * i), 1'b1);
      end
      chk("rx irq withheld", 32'h40, seen);
      rc(1'b1, OFS_COUNT, 32'h0102, "repeat reload");
      rc(1'b1, OFS_CTRL, 32'hf5, "repeat enabled");
      wr(1'b1, OFS_CTRL, 32'h0);
      ack_delay <= 4'h0;
   endtask
   task automatic t_idle();
      setup(1'b1, 32'h300, 32'h60, 32'h1);
      en(1'b1, 8'h9e);
      fire(6);
      get(1'b1, 32'hff000300, 32'hffffff60, 1'b0);
      rc(1'b1, OFS_CTRL, 32'h1e, "idle end");
      chk("end irq", 32'h2, transfer_end_irq);
      rc(1'b1, OFS_ADDR, 32'hff000300, "idle address");
      wr(1'b1, OFS_CTRL, 32'h16);
      repeat (2) @(posedge sys_clk);
      chk("end irq cleared", 0, transfer_end_irq);
      wr(1'b1, OFS_COUNT, 32'h1);
      en(1'b1, 8'hc7);
      fire(7);
      get(1'b1, 32'hff000300, 32'hffffff60, 1'b1);
      rc(1'b1, OFS_CTRL, 32'h47, "level end");
      chk("no end irq", 0, transfer_end_irq);
   endtask
   task automatic t_full();
      setup(1'b0, 32'h400, 32'h77, 32'h1);
      setup(1'b1, 32'h500, 32'h78, 32'h5);
      wr(1'b1, OFS_CTRL, 32'h24);
      en(1'b0, 8'h86);
      seen = 7'h0;
      fire(4);
      get(1'b0, 32'hff000400, 32'hff000500, 1'b0);
      chk("tx irq withheld", 32'h40, seen);
      rc(1'b0, OFS_CTRL, 32'h06, "full end");
      rc(1'b1, OFS_ADDR, 32'hff0004ff, "dest down");
      rc(1'b1, OFS_COUNT, 32'h5, "b count");
   endtask
   initial
   begin
      {rst, standby, psel, penable, pwrite, external_request_pin_n} = 6'h21;
      {serial_tx_empty, serial_rx_full, timer_match, ack_delay} = 10'h0;
      {paddr, pwdata, seen, n_mismatch, check_count} = '0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_regs();
      t_prio();
      t_repeat();
      t_idle();
      t_full();
      wrap_up();
   end
endmodule
`default_nettype wire
